// ### shared/motion_irq_params.svh
// offsets, field positions, reset values and sizes of the motion/fifo/irq block
// assumes 7-bit register addresses and 8-bit register data
`ifndef MOTION_IRQ_PARAMS_SVH
`define MOTION_IRQ_PARAMS_SVH
`define RA_SMPL_DIV 7'h19
`define RA_ACC_CFG2 7'h1d
`define RA_THR_X 7'h20
`define RA_THR_Y 7'h21
`define RA_THR_Z 7'h22
`define RA_FIFO_SEL 7'h23
`define RA_PIN_CFG 7'h37
`define RA_IRQ_EN 7'h38
`define RA_IRQ_STAT 7'h3a
`define RA_DATA_FIRST 7'h3b
`define RA_DATA_LAST 7'h48
`define RA_WM_HI 7'h60
`define RA_WM_LO 7'h61
`define RA_MOT_CTRL 7'h69
`define RA_PWR1 7'h6b
`define RA_PWR2 7'h6c
`define RA_CNT_HI 7'h72
`define RA_CNT_LO 7'h73
`define RA_FIFO_DATA 7'h74
// irq enable and status bit layout
`define B_MOT_X 7
`define B_OVF 4
`define B_FSY 3
`define B_WM 2
`define B_CLK 1
`define B_DRDY 0
`define SEC_MAP 8'hf8
`define PRI_MAP 8'h07
// pin config
`define B_ACT_LOW 7
`define B_OPEN_DRAIN 6
`define B_LATCH 5
`define B_ANY_RD_CLR 4
`define B_SEC_EN 0
// motion logic control
`define B_LOGIC_EN 7
`define B_CMP_MODE 6
`define B_COMBINE 0
// power control
`define B_SLEEP 6
`define B_CYCLE 5
`define B_GSTBY 4
`define B_GCYCLE 3
// fifo select
`define B_SEL_TEMP 7
`define B_SEL_GYRO 6
`define B_SEL_ACC 3
`define B_SEL_FSY 0
`define RST_PWR1 8'h40
`define RST_REG 8'h00
`define FIFO_DEPTH 1008
`define FRAME_LAST 4'he
`define THR_SHIFT 4
`endif

// ### shared/motion_irq_pkg.sv
// types shared by the motion/fifo/irq block
// assumes sensor words are 16-bit two's complement
package motion_irq_pkg;
  typedef logic [15:0] word_t;
  typedef struct packed {
    word_t ax;
    word_t ay;
    word_t az;
    word_t temp;
    word_t gx;
    word_t gy;
    word_t gz;
  } sample_s;
  typedef struct packed {
    word_t x;
    word_t y;
    word_t z;
  } hp_s;
  typedef enum logic [2:0] {
    PM_SLEEP, PM_STANDBY, PM_ACC_LP, PM_ACC_LN,
    PM_GYR_LP, PM_GYR_LN, PM_6AX_LN, PM_6AX_LP
  } power_mode_e;
  typedef enum logic {WR_IDLE, WR_RUN} fill_state_e;
endpackage

// ### logic/byte_fifo_mem.sv
// byte memory behind the sample fifo
// assumes read address is always below DEPTH; read data is registered
`timescale 1ns/1ns
module byte_fifo_mem #(
  parameter int DEPTH = 1008,
  parameter int AW = 10
) (
  input wire logic sys_clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem_q [DEPTH];

  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en_i)
      mem_q[wr_addr_i] <= wr_data_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule

// ### logic/motion_irq_top.sv
// sensor data registers, sample fifo, wake-on-motion and irq pin logic
// assumes a serial front end that issues one register access per strobe
`timescale 1ns/1ns
`include "motion_irq_params.svh"

// Function
// - latest sensor samples readable any time
// - sample fifo holds 1008 bytes
// - fifo select picks stored data kinds
// - byte count kept; burst reads pop bytes
// - fifo readable in accel duty-cycle mode
// - watermark reached raises watermark interrupt
// - lock, data, motion, overflow raise interrupts
// - pin drive, latching, clearing, triggers configurable
// - status register shows interrupt causes
// - every source has own enable
// - motion/overflow/frame_sync_input secondary; watermark/ready primary
// - secondary disabled sends all to primary
// - motion when axis magnitude exceeds threshold
// - eight power modes decoded
// - per-axis motion enables, disabled axes ignored
// - three per-axis motion thresholds
// - combine select: or when 0, and when 1
// - divider sets accel wake rate
// - cycle bit puts accel into duty cycle only while the gyro is off
module motion_irq_top
  import motion_irq_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int THR_SHIFT = `THR_SHIFT
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic sample_valid_i,
  input wire sample_s sample_i,
  input wire hp_s hp_i,
  input wire logic rate_tick_i,
  input wire logic clk_locked_i,
  input wire logic frame_sync_input_i,
  output logic primary_irq_pin_o,
  output logic primary_irq_pin_oe_o,
  output logic secondary_irq_pin_o,
  output logic secondary_irq_pin_oe_o,
  output power_mode_e power_mode_o,
  output logic accel_wake_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [7:0] smpl_div_q, acc_cfg2_q, fifo_sel_q, pin_cfg_q, irq_en_q;
  logic [7:0] mot_ctrl_q, pwr1_q, pwr2_q, stat_q, pulse_q, rd_hold_q;
  logic [7:0] thr_q [3];
  logic [9:0] wm_q;
  sample_s sample_q;
  logic fs_meta_q, fs_sync_q, fs_prev_q;
  fill_state_e fill_q;
  logic [3:0] idx_q;
  logic [119:0] frame_q;
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [7:0] mem_rd;
  logic rd_pend_q, rd_fifo_q;
  logic [7:0] wake_cnt_q;
  logic push, push_ok, pop, ovf, wm_hit, mot_evt, or_hit, and_hit;
  logic [2:0] exceed, ax_en;
  logic [7:0] ev, clr, rd_mux, src;
  logic pri_act, sec_act;
  power_mode_e mode_d;

  function automatic logic sel_byte(input logic [3:0] i, input logic [7:0] sel);
    if (i < 4'h6)
      return sel[`B_SEL_ACC];
    else if (i < 4'h8)
      return sel[`B_SEL_TEMP];
    else if (i < 4'he)
      return sel[`B_SEL_GYRO];
    return sel[`B_SEL_FSY];
  endfunction

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [15:0] magnitude(input logic [15:0] v);
    return v[15] ? 16'(~v + 16'h1) : v;
  endfunction

  // host register writes
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      smpl_div_q <= `RST_REG;
      acc_cfg2_q <= `RST_REG;
      fifo_sel_q <= `RST_REG;
      pin_cfg_q <= `RST_REG;
      irq_en_q <= `RST_REG;
      mot_ctrl_q <= `RST_REG;
      pwr1_q <= `RST_PWR1;
      pwr2_q <= `RST_REG;
      wm_q <= 10'h0;
      for (int i = 0; i < 3; i++)
        thr_q[i] <= `RST_REG;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `RA_SMPL_DIV: smpl_div_q <= reg_wdata_i;
        `RA_ACC_CFG2: acc_cfg2_q <= reg_wdata_i;
        `RA_THR_X: thr_q[0] <= reg_wdata_i;
        `RA_THR_Y: thr_q[1] <= reg_wdata_i;
        `RA_THR_Z: thr_q[2] <= reg_wdata_i;
        `RA_FIFO_SEL: fifo_sel_q <= reg_wdata_i;
        `RA_PIN_CFG: pin_cfg_q <= reg_wdata_i;
        `RA_IRQ_EN: irq_en_q <= reg_wdata_i;
        `RA_WM_HI: wm_q[9:8] <= reg_wdata_i[1:0];
        `RA_WM_LO: wm_q[7:0] <= reg_wdata_i;
        `RA_MOT_CTRL: mot_ctrl_q <= reg_wdata_i;
        `RA_PWR1: pwr1_q <= reg_wdata_i;
        `RA_PWR2: pwr2_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // sensor data registers; only the producer changes them
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      sample_q <= '0;
    else if (sample_valid_i)
      sample_q <= sample_i;
  end

  // frame sync pin: two flops before any edge detection
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      fs_meta_q <= 1'b0;
      fs_sync_q <= 1'b0;
      fs_prev_q <= 1'b0;
    end
    else
    begin
      fs_meta_q <= frame_sync_input_i;
      fs_sync_q <= fs_meta_q;
      fs_prev_q <= fs_sync_q;
    end
  end

  // fifo fill: one byte per cycle; a sample arriving mid-frame is skipped
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      fill_q <= WR_IDLE;
      idx_q <= 4'h0;
      frame_q <= '0;
    end
    else
    begin
      case (fill_q)
        WR_IDLE:
        begin
          if (sample_valid_i && fifo_sel_q != 8'h00)
          begin
            frame_q <= {sample_i, 7'h0, fs_sync_q};
            idx_q <= 4'h0;
            fill_q <= WR_RUN;
          end
        end
        WR_RUN:
        begin
          idx_q <= idx_q + 4'h1;
          if (idx_q == `FRAME_LAST)
            fill_q <= WR_IDLE;
        end
        default: fill_q <= WR_IDLE;
      endcase
    end
  end

  assign push = (fill_q == WR_RUN) && sel_byte(idx_q, fifo_sel_q);
  assign push_ok = push && (cnt_q != CW'(DEPTH));
  assign ovf = push && (cnt_q == CW'(DEPTH));
  // not gated by power mode, so duty-cycled accel still drains
  assign pop = reg_rd_i && reg_addr_i == `RA_FIFO_DATA && cnt_q != '0;

  always_comb
  begin
    cnt_d = cnt_q;
    if (push_ok && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push_ok)
      cnt_d = cnt_q - 1'b1;
  end

  assign wm_hit = wm_q != 10'h0 && CW'(wm_q) == cnt_d && cnt_q < CW'(wm_q);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push_ok)
        wr_ptr_q <= next_ptr(wr_ptr_q);
      if (pop)
        rd_ptr_q <= next_ptr(rd_ptr_q);
      cnt_q <= cnt_d;
    end
  end

  byte_fifo_mem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .sys_clk_i(sys_clk_i),
    .wr_en_i(push_ok),
    .wr_addr_i(wr_ptr_q),
    .wr_data_i(frame_q[119 - 8 * idx_q -: 8]),
    .rd_addr_i(rd_ptr_q),
    .rd_data_o(mem_rd)
  );

  // per-axis motion compare
  assign ax_en = irq_en_q[`B_MOT_X -: 3];
  for (genvar g = 0; g < 3; g++)
  begin : g_axis
    logic [15:0] mag;
    assign mag = magnitude(hp_i[47 - 16 * g -: 16]);
    // x sits in the top enable bit, so flip the index to line up with ax_en
    assign exceed[2 - g] = (mag >> THR_SHIFT) > {8'h0, thr_q[g]};
  end
  assign or_hit = |(exceed & ax_en);
  assign and_hit = ax_en != 3'b000 && (exceed & ax_en) == ax_en;
  assign mot_evt = sample_valid_i && mot_ctrl_q[`B_LOGIC_EN]
    && mot_ctrl_q[`B_CMP_MODE]
    && (mot_ctrl_q[`B_COMBINE] ? and_hit : or_hit);

  // raw events, high in every cycle their source condition holds
  always_comb
  begin
    ev = 8'h00;
    ev[`B_MOT_X -: 3] = {3{mot_evt}} & exceed & ax_en;
    ev[`B_OVF] = ovf;
    ev[`B_FSY] = fs_sync_q && !fs_prev_q;
    ev[`B_WM] = wm_hit;
    ev[`B_CLK] = clk_locked_i;
    ev[`B_DRDY] = sample_valid_i;
  end

  assign clr = (reg_rd_i && (reg_addr_i == `RA_IRQ_STAT || pin_cfg_q[`B_ANY_RD_CLR]))
    ? 8'hff : 8'h00;

  // sticky status; a set in the clearing cycle survives
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      stat_q <= 8'h00;
      pulse_q <= 8'h00;
    end
    else
    begin
      stat_q <= (stat_q & ~clr) | (ev & irq_en_q);
      pulse_q <= ev & irq_en_q;
    end
  end

  assign src = pin_cfg_q[`B_LATCH] ? stat_q : pulse_q;
  assign sec_act = pin_cfg_q[`B_SEC_EN] && |(src & `SEC_MAP);
  assign pri_act = |(src & (pin_cfg_q[`B_SEC_EN] ? `PRI_MAP : 8'hff));

  // open drain drives only the active level, so the pin is driven just while active
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      primary_irq_pin_o <= 1'b0;
      primary_irq_pin_oe_o <= 1'b0;
      secondary_irq_pin_o <= 1'b0;
      secondary_irq_pin_oe_o <= 1'b0;
    end
    else
    begin
      primary_irq_pin_o <= pin_cfg_q[`B_OPEN_DRAIN] ? !pin_cfg_q[`B_ACT_LOW]
        : pri_act ^ pin_cfg_q[`B_ACT_LOW];
      primary_irq_pin_oe_o <= !pin_cfg_q[`B_OPEN_DRAIN] || pri_act;
      secondary_irq_pin_o <= pin_cfg_q[`B_OPEN_DRAIN] ? !pin_cfg_q[`B_ACT_LOW]
        : sec_act ^ pin_cfg_q[`B_ACT_LOW];
      secondary_irq_pin_oe_o <= !pin_cfg_q[`B_OPEN_DRAIN] || sec_act;
    end
  end

  // power mode table
  always_comb
  begin
    logic acc_on, gyr_on;
    acc_on = pwr2_q[5:3] != 3'b111;
    gyr_on = pwr2_q[2:0] != 3'b111 && !pwr1_q[`B_GSTBY];
    if (pwr1_q[`B_SLEEP])
      mode_d = PM_SLEEP;
    else if (pwr1_q[`B_GSTBY] && pwr2_q[2:0] != 3'b111 && !acc_on)
      mode_d = PM_STANDBY;
    else if (acc_on && gyr_on)
      mode_d = pwr1_q[`B_GCYCLE] ? PM_6AX_LP : PM_6AX_LN;
    else if (acc_on)
      mode_d = pwr1_q[`B_CYCLE] ? PM_ACC_LP : PM_ACC_LN;
    else if (gyr_on)
      mode_d = pwr1_q[`B_GCYCLE] ? PM_GYR_LP : PM_GYR_LN;
    else
      mode_d = PM_SLEEP;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      power_mode_o <= PM_SLEEP;
    else
      power_mode_o <= mode_d;
  end

  // wake rate = tick rate / (divider + 1)
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wake_cnt_q <= 8'h00;
      accel_wake_o <= 1'b0;
    end
    else
    begin
      accel_wake_o <= 1'b0;
      if (mode_d != PM_ACC_LP)
        wake_cnt_q <= 8'h00;
      else if (rate_tick_i)
      begin
        if (wake_cnt_q >= smpl_div_q)
        begin
          wake_cnt_q <= 8'h00;
          accel_wake_o <= 1'b1;
        end
        else
          wake_cnt_q <= wake_cnt_q + 8'h01;
      end
    end
  end

  // read mux, sampled before the read's own clear takes effect
  always_comb
  begin
    logic [15:0] cnt16;
    cnt16 = 16'(cnt_q);
    case (reg_addr_i)
      `RA_SMPL_DIV: rd_mux = smpl_div_q;
      `RA_ACC_CFG2: rd_mux = acc_cfg2_q;
      `RA_THR_X: rd_mux = thr_q[0];
      `RA_THR_Y: rd_mux = thr_q[1];
      `RA_THR_Z: rd_mux = thr_q[2];
      `RA_FIFO_SEL: rd_mux = fifo_sel_q;
      `RA_PIN_CFG: rd_mux = pin_cfg_q;
      `RA_IRQ_EN: rd_mux = irq_en_q;
      `RA_IRQ_STAT: rd_mux = stat_q;
      `RA_WM_HI: rd_mux = {6'h0, wm_q[9:8]};
      `RA_WM_LO: rd_mux = wm_q[7:0];
      `RA_MOT_CTRL: rd_mux = mot_ctrl_q;
      `RA_PWR1: rd_mux = pwr1_q;
      `RA_PWR2: rd_mux = pwr2_q;
      `RA_CNT_HI: rd_mux = cnt16[15:8];
      `RA_CNT_LO: rd_mux = cnt16[7:0];
      default:
      begin
        if (reg_addr_i >= `RA_DATA_FIRST && reg_addr_i <= `RA_DATA_LAST)
          rd_mux = sample_q[111 - 8 * (reg_addr_i - `RA_DATA_FIRST) -: 8];
        else
          rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rd_pend_q <= 1'b0;
      rd_fifo_q <= 1'b0;
      rd_hold_q <= 8'h00;
      reg_rvalid_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      rd_pend_q <= reg_rd_i;
      rd_fifo_q <= pop;
      rd_hold_q <= rd_mux;
      reg_rvalid_o <= rd_pend_q;
      if (rd_pend_q)
        reg_rdata_o <= rd_fifo_q ? mem_rd : rd_hold_q;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_latched_pin;
    pin_cfg_q[`B_LATCH] && !pin_cfg_q[`B_OPEN_DRAIN] && !reg_wr_i && !reg_rd_i;
  endsequence

  property p_sample_regs;
    sample_valid_i |=> sample_q == $past(sample_i);
  endproperty
  a_sample_regs: assert property (p_sample_regs) else $error("sample not latched");

  property p_depth;
    cnt_q <= CW'(DEPTH) && !(cnt_q == CW'(DEPTH) && push_ok);
  endproperty
  a_depth: assert property (p_depth) else $error("fifo count past depth");

  property p_pop_count;
    pop && !push_ok |=> cnt_q == $past(cnt_q) - 1'b1 ##1 reg_rvalid_o;
  endproperty
  a_pop_count: assert property (p_pop_count) else $error("pop count or answer");

  property p_watermark;
    wm_hit |=> cnt_q == CW'($past(wm_q)) && stat_q[`B_WM] == $past(irq_en_q[`B_WM]);
  endproperty
  a_watermark: assert property (p_watermark) else $error("watermark event wrong");

  property p_flag_set;
    (ev & irq_en_q) != 8'h00 |=> (stat_q & $past(ev & irq_en_q)) == $past(ev & irq_en_q);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("enabled event lost");

  property p_all_primary;
    s_latched_pin ##0 (!pin_cfg_q[`B_SEC_EN] && stat_q != 8'h00) |=> ##1
      primary_irq_pin_o == !pin_cfg_q[`B_ACT_LOW] && secondary_irq_pin_o == pin_cfg_q[`B_ACT_LOW];
  endproperty
  a_all_primary: assert property (p_all_primary) else $error("primary pin not active");

  property p_secondary_map;
    s_latched_pin ##0 (pin_cfg_q[`B_SEC_EN] && (stat_q & `SEC_MAP) != 8'h00)
      |=> ##1 secondary_irq_pin_o == !pin_cfg_q[`B_ACT_LOW];
  endproperty
  a_secondary_map: assert property (p_secondary_map) else $error("secondary pin idle");

  property p_combine;
    mot_evt |-> (mot_ctrl_q[`B_COMBINE] ? (exceed & ax_en) == ax_en : (exceed & ax_en) != 3'b000)
      && ax_en != 3'b000;
  endproperty
  a_combine: assert property (p_combine) else $error("motion combine wrong");

  property p_wake_rate;
    accel_wake_o |=> !accel_wake_o;
  endproperty
  a_wake_rate: assert property (p_wake_rate) else $error("wake pulse too long");
endmodule

// ### test/host_model.sv
// host side of the register port: strobed writes, reads with a bounded wait
// assumes the block answers a read within a few cycles of its strobe
`timescale 1ns/1ns
`include "motion_irq_params.svh"
module host_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic [6:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  // position of the filter bypass flag; plain default
  localparam int FILT_BYP_BIT = 3;
  initial
  begin
    reg_addr_o = 7'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // idle address and data inverted so stale values never pass for live ones
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    for (int i = 0; i < 8 && !ok; i++)
    begin
      @(negedge sys_clk_i);
      if (reg_rvalid_i === 1'b1)
      begin
        ok = 1'b1;
        d = reg_rdata_i;
      end
    end
  endtask
  // motion bring-up; ctrl must carry logic enable and compare mode
  task automatic wom_setup(input logic [7:0] ena, input logic [7:0] ctrl,
    input logic [7:0] div, input logic [23:0] thr);
    wr(`RA_PWR1, 8'h00);
    wr(`RA_PWR2, 8'h07);
    wr(`RA_ACC_CFG2, 8'h01 | (8'h01 << FILT_BYP_BIT));
    wr(`RA_IRQ_EN, ena);
    wr(`RA_THR_X, thr[23:16]);
    wr(`RA_THR_Y, thr[15:8]);
    wr(`RA_THR_Z, thr[7:0]);
    wr(`RA_MOT_CTRL, ctrl);
    wr(`RA_SMPL_DIV, div);
    wr(`RA_PWR1, 8'h01 << `B_CYCLE);
  endtask
endmodule

// ### test/testbench.sv
// self-checking bench for the motion, fifo and irq block
// assumes host_model drives the register port; sensor inputs driven here
`timescale 1ns/1ns
`include "motion_irq_params.svh"
module testbench;
  import motion_irq_pkg::*;
  localparam logic [7:0] SEL [4] = '{8'h08, 8'h80, 8'h40, 8'h01};
  localparam int NB [4] = '{6, 2, 6, 1};
  localparam int TOP [4] = '{111, 63, 47, -1};
  localparam logic [7:0] M_EN [6] = '{8'he0, 8'he0, 8'he0, 8'he0, 8'h40, 8'h20};
  localparam logic [7:0] M_CTL [6] = '{8'hc0, 8'hc0, 8'hc1, 8'hc1, 8'hc0, 8'hc0};
  localparam logic [2:0] M_ABV [6] = '{3'b100, 3'b000, 3'b100, 3'b111, 3'b100, 3'b001};
  localparam bit M_NEG [6] = '{0, 0, 0, 1, 0, 1};
  localparam bit M_EXP [6] = '{1, 0, 0, 1, 0, 1};
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [6:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_wdata, reg_rdata;
  logic sample_valid = 1'b0;
  sample_s smp = '0;
  hp_s hp = '0;
  logic rate_tick = 1'b0;
  logic clk_locked = 1'b0;
  logic frame_sync_input = 1'b0;
  logic pri_o, pri_oe, sec_o, sec_oe, wake;
  power_mode_e mode;
  int failures = 0;
  int n_tests = 0;
  int wakes = 0;
  int seed = int'(32'h895c418b);

  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
    if (wake === 1'b1)
      wakes++;

  motion_irq_top i_motion_irq_top (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .reg_rvalid_o(reg_rvalid), .sample_valid_i(sample_valid), .sample_i(smp), .hp_i(hp),
    .rate_tick_i(rate_tick), .clk_locked_i(clk_locked), .frame_sync_input_i(frame_sync_input),
    .primary_irq_pin_o(pri_o), .primary_irq_pin_oe_o(pri_oe), .secondary_irq_pin_o(sec_o),
    .secondary_irq_pin_oe_o(sec_oe), .power_mode_o(mode), .accel_wake_o(wake));
  host_model i_host_model (
    .sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid),
    .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata));

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    bit ok;
    i_host_model.rd(a, d, ok);
    if (!ok)
    begin
      failures++;
      $display("BAD %s expected answer seen none", what);
      wrap_up();
    end
    else
      chk(what, exp, d);
  endtask
  // fresh random sample; spaced past one fifo frame fill
  task automatic send(input hp_s h);
    logic [127:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    @(negedge sys_clk_i);
    smp = r[111:0];
    hp = h;
    sample_valid = 1'b1;
    @(negedge sys_clk_i);
    sample_valid = 1'b0;
    repeat (18) @(negedge sys_clk_i);
  endtask
  task automatic lock_pulse();
    @(negedge sys_clk_i);
    clk_locked = 1'b1;
    @(negedge sys_clk_i);
    clk_locked = 1'b0;
    repeat (3) @(negedge sys_clk_i);
  endtask
  function automatic word_t hpv(input logic [7:0] thr, input bit above, input bit neg);
    word_t v;
    v = {4'h0, thr + {7'h0, above}, 4'h0};
    return neg ? -v : v;
  endfunction

  initial
  begin
    logic [31:0] r;
    logic [23:0] thr;
    logic [7:0] d;
    bit ok;
    int i;
    logic pin;
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    chk("mode", {5'h0, PM_SLEEP}, {5'h0, mode});
    rchk(`RA_PWR1, `RST_PWR1, "pwr1");
    rchk(7'h7f, 8'h00, "unmapped");
    r = $random(seed);
    thr = {2'b0, r[5:0], 2'b0, r[13:8], 2'b0, r[21:16]} + 24'h010101;
    for (int k = 0; k < 3; k++)
    begin
      i_host_model.wr(7'(`RA_THR_X + k), thr[23-8*k -: 8]);
      rchk(7'(`RA_THR_X + k), thr[23-8*k -: 8], "threshold");
    end
    i_host_model.wr(`RA_PIN_CFG, 8'h21);
    i_host_model.wr(`RA_IRQ_EN, 8'h07);
    i_host_model.wr(`RA_WM_LO, 8'h06);
    for (int e = 0; e < 4; e++)
    begin
      // sync pin raised well before the frame so the synchroniser has settled
      frame_sync_input = (e == 3);
      i_host_model.wr(`RA_FIFO_SEL, SEL[e]);
      send('0);
      for (int b = 0; b < 14; b++)
        rchk(7'(`RA_DATA_FIRST + b), smp[111-8*b -: 8], "data reg");
      rchk(`RA_CNT_LO, 8'(NB[e]), "count");
      chk("pin1 held", 8'h01, {7'h0, pri_o});
      rchk(`RA_IRQ_STAT, (NB[e] == 6) ? 8'h05 : 8'h01, "status");
      repeat (2) @(negedge sys_clk_i);
      chk("pin1 cleared", 8'h00, {7'h0, pri_o});
      for (int b = 0; b < NB[e]; b++)
        rchk(`RA_FIFO_DATA, (TOP[e] < 0) ? 8'h01 : smp[TOP[e]-8*b -: 8], "fifo");
      rchk(`RA_CNT_LO, 8'h00, "count empty");
    end
    rchk(`RA_FIFO_DATA, 8'h00, "empty pop");
    lock_pulse();
    rchk(`RA_IRQ_STAT, 8'h02, "lock status");
    i_host_model.wr(`RA_IRQ_EN, 8'h10);
    lock_pulse();
    rchk(`RA_IRQ_STAT, 8'h00, "lock disabled");
    i_host_model.wr(`RA_FIFO_SEL, 8'h08);
    repeat (`FIFO_DEPTH / 6) send('0);
    rchk(`RA_CNT_HI, 8'h03, "count hi full");
    rchk(`RA_CNT_LO, 8'hf0, "count lo full");
    chk("pin2 idle", 8'h00, {7'h0, sec_o});
    send('0);
    rchk(`RA_CNT_LO, 8'hf0, "count kept");
    chk("pin2 overflow", 8'h01, {7'h0, sec_o});
    rchk(`RA_IRQ_STAT, 8'h10, "overflow status");
    // second reset flushes the full fifo instead of a long drain
    @(negedge sys_clk_i);
    rst_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    rst_i = 1'b0;
    rchk(`RA_CNT_LO, 8'h00, "count after reset");
    i_host_model.wom_setup(8'he0, 8'hc0, 8'h02, thr);
    // mode output is registered one edge behind the power register
    @(negedge sys_clk_i);
    chk("mode", {5'h0, PM_ACC_LP}, {5'h0, mode});
    wakes = 0;
    repeat (30)
    begin
      @(negedge sys_clk_i);
      rate_tick = 1'b1;
      @(negedge sys_clk_i);
      rate_tick = 1'b0;
    end
    repeat (3) @(negedge sys_clk_i);
    chk("wakes", 8'd10, 8'(wakes));
    i_host_model.wr(`RA_FIFO_SEL, 8'h08);
    send('0);
    rchk(`RA_CNT_LO, 8'h06, "lp count");
    rchk(`RA_FIFO_DATA, smp[111 -: 8], "lp fifo");
    i_host_model.wr(`RA_FIFO_SEL, 8'h00);
    i_host_model.rd(`RA_IRQ_STAT, d, ok);
    for (int m = 0; m < 7; m++)
    begin
      i = m % 6;
      i_host_model.wr(`RA_PIN_CFG, (m == 6) ? 8'h20 : 8'h21);
      i_host_model.wr(`RA_IRQ_EN, M_EN[i]);
      i_host_model.wr(`RA_MOT_CTRL, M_CTL[i]);
      send({hpv(thr[23:16], M_ABV[i][2], M_NEG[i]), hpv(thr[15:8], M_ABV[i][1], M_NEG[i]),
        hpv(thr[7:0], M_ABV[i][0], M_NEG[i])});
      pin = (m == 6) ? pri_o : sec_o;
      chk("motion pin", {7'h0, M_EXP[i]}, {7'h0, pin});
      i_host_model.rd(`RA_IRQ_STAT, d, ok);
      chk("motion answer", 8'h01, {7'h0, ok});
      chk("motion flag", {7'h0, M_EXP[i]}, {7'h0, |(d & 8'he0)});
    end
    // active-low latched pin, cleared by a read of any register
    i_host_model.wr(`RA_IRQ_EN, 8'h01);
    i_host_model.wr(`RA_PIN_CFG, 8'hb1);
    repeat (2) @(negedge sys_clk_i);
    chk("pin1 idle low", 8'h01, {7'h0, pri_o});
    chk("pin1 oe push-pull", 8'h01, {7'h0, pri_oe});
    send('0);
    chk("pin1 active low", 8'h00, {7'h0, pri_o});
    rchk(`RA_PWR2, 8'h07, "any read");
    repeat (2) @(negedge sys_clk_i);
    chk("pin1 any-read clear", 8'h01, {7'h0, pri_o});
    // open drain: driven only while the source is active
    i_host_model.wr(`RA_PIN_CFG, 8'h61);
    repeat (2) @(negedge sys_clk_i);
    chk("pin1 oe idle", 8'h00, {7'h0, pri_oe});
    chk("pin2 oe idle", 8'h00, {7'h0, sec_oe});
    send('0);
    chk("pin1 oe active", 8'h01, {7'h0, pri_oe});
    chk("pin1 od level", 8'h01, {7'h0, pri_o});
    chk("pin2 oe unmapped", 8'h00, {7'h0, sec_oe});
    wrap_up();
  end
endmodule
